/* File: hdl/ssrd_pkg.sv */
// Constants and types for the script I/O and read/write decoder
package ssrd_pkg;

  // ****************************************
  // Instruction fields
  // ****************************************
  localparam int          TYPE_HI   = 31;
  localparam int          TYPE_LO   = 30;
  localparam int          OPC_HI    = 29;
  localparam int          OPC_LO    = 27;
  localparam int          BIT_REL   = 26;
  localparam int          BIT_TBL   = 25;
  localparam int          BIT_SATN  = 24;
  localparam int          OPR_HI    = 26;
  localparam int          OPR_LO    = 24;
  localparam int          BIT_ACC   = 23;
  localparam int          RADR_HI   = 22;
  localparam int          RADR_LO   = 16;
  localparam int          DID_HI    = 19;
  localparam int          DID_LO    = 16;
  localparam int          IMM_HI    = 15;
  localparam int          IMM_LO    = 8;
  localparam int          BIT_CC    = 10;
  localparam int          BIT_TM    = 9;
  localparam int          BIT_ACK   = 6;
  localparam int          BIT_ATN   = 3;
  localparam logic [1:0]  TYPE_IO   = 2'h1;
  localparam logic [2:0]  OPC_SEL   = 3'h0;
  localparam logic [2:0]  OPC_WDIS  = 3'h1;
  localparam logic [2:0]  OPC_WRES  = 3'h2;
  localparam logic [2:0]  OPC_SET   = 3'h3;
  localparam logic [2:0]  OPC_CLR   = 3'h4;
  localparam logic [2:0]  OPC_MFROM = 3'h5;
  localparam logic [2:0]  OPC_MTO   = 3'h6;
  localparam logic [2:0]  OPC_RMW   = 3'h7;

  // ****************************************
  // APB register map
  // ****************************************
  localparam logic [11:0] ADR_INSTR0 = 12'h000;
  localparam logic [11:0] ADR_INSTR1 = 12'h004;
  localparam logic [11:0] ADR_SPTR   = 12'h008;
  localparam logic [11:0] ADR_DBASE  = 12'h00c;
  localparam logic [11:0] ADR_CTRL   = 12'h010;
  localparam logic [11:0] ADR_STAT   = 12'h014;
  localparam logic [11:0] ADR_ALU    = 12'h018;
  localparam logic [11:0] ADR_NEXT   = 12'h01c;
  localparam logic [11:0] ADR_TFETCH = 12'h020;
  localparam logic [11:0] ADR_REGW   = 12'h024;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // CTRL: bit0 go, bit1 selected, bit2 reselected, bit3 signal process,
  //       bit4 loopback, bits15:8 register read value
  localparam int          CTL_GO    = 0;
  localparam int          CTL_SELD  = 1;
  localparam int          CTL_RSELD = 2;
  localparam int          CTL_SIGNAL_PROCESS_FLAG  = 3;
  localparam int          CTL_LOOP  = 4;

  // Read/write operators
  typedef enum logic [2:0] {
    OP_MOV = 3'h0, OP_SHL = 3'h1, OP_OR  = 3'h2, OP_XOR = 3'h3,
    OP_AND = 3'h4, OP_SHR = 3'h5, OP_ADD = 3'h6, OP_ADC = 3'h7
  } ssrd_op_t;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ssrd_apb_req_t;

  // Bus latch outputs
  typedef struct packed {
    logic ack;
    logic atn;
  } ssrd_latch_t;

endpackage

/* File: hdl/ssrd_decoder.sv */
// Script I/O and read/write instruction decoder with APB registers
`timescale 1ns/1ns
`default_nettype none
module ssrd_decoder (
  input  wire logic                   sys_clk,    // Core clock
  input  wire logic                   reset_n,    // Async reset
  input  wire ssrd_pkg::ssrd_apb_req_t apbReq,    // APB request
  output logic [31:0]                 prdata,     // APB read data
  output logic                        pready,     // APB ready
  output logic                        pslverr,    // APB error
  output ssrd_pkg::ssrd_latch_t       busDrive,   // ACK/ATN driven on bus
  output logic                        targetMode, // Control zero bit 0
  output logic                        illegalIrq, // Illegal instruction pulse
  output logic                        selAtn      // ATN during selection
);
  import ssrd_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } ssrd_state_t;

  // ****************************************
  // Registers
  // ****************************************
  ssrd_state_t state;
  logic [31:0] instr0;
  logic [31:0] nextAddress;     // Second instruction word
  logic [31:0] scriptPointer;
  logic [31:0] dataBase;
  logic [31:0] nextFetch;       // Address of next instruction
  logic [31:0] tableFetch;      // Table entry address
  logic [7:0]  firstByte;       // First byte received register
  logic [7:0]  regFile [0:127];
  logic [7:0]  latchBits;       // Output control latch
  logic        carry;
  logic        loopback;
  logic        selected;
  logic        reselected;
  logic        sigProc;
  logic        goReq;
  logic [3:0]  destId;
  logic        tableFetchReq;

  // ****************************************
  // Field decode
  // ****************************************
  logic [1:0]  iType;
  logic [2:0]  iOpc;
  logic        isIo;
  logic        relMode;
  logic        tblMode;
  logic [31:0] altTarget;
  logic [31:0] tblAddr;
  logic [7:0]  opA;
  logic [7:0]  opB;
  logic [6:0]  rAdr;
  logic [7:0]  aluRes;
  logic        aluCarry;
  logic [8:0]  sum;
  logic        apbWr;
  logic        apbAcc;

  assign iType   = instr0[TYPE_HI:TYPE_LO];
  assign iOpc    = instr0[OPC_HI:OPC_LO];
  assign isIo    = (iOpc <= OPC_CLR);
  assign relMode = instr0[BIT_REL];
  assign tblMode = instr0[BIT_TBL];
  assign rAdr    = instr0[RADR_HI:RADR_LO];
  assign apbAcc  = apbReq.psel & apbReq.penable;
  assign apbWr   = apbAcc & apbReq.pwrite;

  // Alternate target: absolute or signed displacement
  assign altTarget = relMode
    ? scriptPointer + {{8{nextAddress[23]}}, nextAddress[23:0]}
    : nextAddress;
  assign tblAddr = dataBase + {{8{instr0[23]}}, instr0[23:0]};

  // ALU operands and operation
  always_comb
  begin
    opA = (iOpc == OPC_MFROM) ? firstByte : regFile[rAdr];
    opB = instr0[BIT_ACC] ? firstByte : instr0[IMM_HI:IMM_LO];
    sum = 9'h000;
    aluCarry = carry;
    case (ssrd_op_t'(instr0[OPR_HI:OPR_LO]))
      OP_MOV: aluRes = instr0[IMM_HI:IMM_LO];
      OP_SHL:
      begin
        aluRes   = {opA[6:0], carry};
        aluCarry = opA[7];
      end
      OP_OR:  aluRes = opA | opB;
      OP_XOR: aluRes = opA ^ opB;
      OP_AND: aluRes = opA & opB;
      OP_SHR:
      begin
        aluRes   = {carry, opA[7:1]};
        aluCarry = opA[0];
      end
      OP_ADD:
      begin
        sum      = {1'b0, opA} + {1'b0, opB};
        aluRes   = sum[7:0];
        aluCarry = sum[8];
      end
      default:
      begin
        sum      = {1'b0, opA} + {1'b0, opB} + {8'h00, carry};
        aluRes   = sum[7:0];
        aluCarry = sum[8];
      end
    endcase
  end

  // ****************************************
  // Execution state machine
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ST_IDLE;
    else
      case (state)
        ST_IDLE: if (goReq) state <= ST_EXEC;
        ST_EXEC:
          if (iType == TYPE_IO && isIo && iOpc == OPC_WRES &&
              !instr0[BIT_SATN])
            state <= ST_WAIT;
          else
            state <= ST_DONE;
        ST_WAIT:
          if (sigProc || selected || reselected) state <= ST_DONE;
        default: state <= ST_IDLE;
      endcase
  end

  // Next fetch address
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      nextFetch <= RESET_WORD;
    else if (state == ST_EXEC)
      nextFetch <= scriptPointer;
    else if (state == ST_WAIT)
    begin
      if (sigProc)
        nextFetch <= altTarget;
      else if (selected)
        nextFetch <= altTarget;
      else if (reselected)
        nextFetch <= scriptPointer;
    end
  end

  // Table entry fetch request
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tableFetch    <= RESET_WORD;
      tableFetchReq <= 1'b0;
      destId        <= 4'h0;
    end
    else if (state == ST_EXEC && iType == TYPE_IO && isIo)
    begin
      tableFetchReq <= tblMode && (iOpc == OPC_SEL || iOpc == OPC_WRES);
      tableFetch    <= tblMode ? tblAddr : tableFetch;
      destId        <= instr0[DID_HI:DID_LO];
    end
  end

  // Set/Clear and attention check; reserved bits ignored
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latchBits  <= 8'h00;
      targetMode <= 1'b0;
      illegalIrq <= 1'b0;
      selAtn     <= 1'b0;
    end
    else
    begin
      illegalIrq <= 1'b0;
      if (state == ST_EXEC && iType == TYPE_IO && isIo)
      begin
        selAtn     <= (iOpc == OPC_SEL) && instr0[BIT_SATN];
        illegalIrq <= (iOpc != OPC_SEL) && instr0[BIT_SATN];
        if (iOpc == OPC_SET && !instr0[BIT_SATN])
        begin
          if (instr0[BIT_ACK]) latchBits[BIT_ACK] <= 1'b1;
          if (instr0[BIT_ATN]) latchBits[BIT_ATN] <= 1'b1;
          if (instr0[BIT_TM])  targetMode <= 1'b1;
        end
        else if (iOpc == OPC_CLR && !instr0[BIT_SATN])
        begin
          if (instr0[BIT_ACK]) latchBits[BIT_ACK] <= 1'b0;
          if (instr0[BIT_ATN]) latchBits[BIT_ATN] <= 1'b0;
          if (instr0[BIT_TM])  targetMode <= 1'b0;
        end
      end
    end
  end

  // Bus drive gated by role and loopback
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      busDrive <= '0;
    else
    begin
      busDrive.ack <= latchBits[BIT_ACK] & (~targetMode | loopback);
      busDrive.atn <= latchBits[BIT_ATN] & (~targetMode | loopback);
    end
  end

  // Carry flag
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      carry <= 1'b0;
    else if (state == ST_EXEC && iType == TYPE_IO)
    begin
      if (!isIo)
        carry <= aluCarry;
      else if (iOpc == OPC_SET && instr0[BIT_CC] && !instr0[BIT_SATN])
        carry <= 1'b1;
      else if (iOpc == OPC_CLR && instr0[BIT_CC] && !instr0[BIT_SATN])
        carry <= 1'b0;
    end
  end

  // Register file and first byte register writeback
  always_ff @(posedge sys_clk)
  begin
    if (state == ST_EXEC && iType == TYPE_IO && !isIo && iOpc != OPC_MTO)
      regFile[rAdr] <= aluRes;
    else if (apbWr && apbReq.paddr == ADR_REGW)
      regFile[apbReq.pwdata[14:8]] <= apbReq.pwdata[7:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      firstByte <= 8'h00;
    else if (state == ST_EXEC && iType == TYPE_IO && iOpc == OPC_MTO)
      firstByte <= aluRes;
  end

  // ****************************************
  // APB slave: writes
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr0        <= RESET_WORD;
      nextAddress   <= RESET_WORD;
      scriptPointer <= RESET_WORD;
      dataBase      <= RESET_WORD;
      loopback      <= 1'b0;
      selected      <= 1'b0;
      reselected    <= 1'b0;
      sigProc       <= 1'b0;
      goReq         <= 1'b0;
    end
    else
    begin
      if (state == ST_IDLE && goReq)
        goReq <= 1'b0;
      if (state == ST_DONE)
      begin
        selected   <= 1'b0;
        reselected <= 1'b0;
        sigProc    <= 1'b0;
      end
      if (apbWr)
      begin
        if (apbReq.paddr == ADR_INSTR0)      instr0        <= apbReq.pwdata;
        else if (apbReq.paddr == ADR_INSTR1) nextAddress   <= apbReq.pwdata;
        else if (apbReq.paddr == ADR_SPTR)   scriptPointer <= apbReq.pwdata;
        else if (apbReq.paddr == ADR_DBASE)  dataBase      <= apbReq.pwdata;
        else if (apbReq.paddr == ADR_CTRL)
        begin
          goReq      <= apbReq.pwdata[CTL_GO] | goReq;
          selected   <= apbReq.pwdata[CTL_SELD];
          reselected <= apbReq.pwdata[CTL_RSELD];
          sigProc    <= apbReq.pwdata[CTL_SIGNAL_PROCESS_FLAG];
          loopback   <= apbReq.pwdata[CTL_LOOP];
        end
      end
    end
  end

  // ****************************************
  // APB slave: reads and answer
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata  <= RESET_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apbReq.psel & ~apbReq.penable;
      pslverr <= 1'b0;
      prdata  <= RESET_WORD;
      if (apbReq.psel && !apbReq.penable)
      begin
        if (apbReq.paddr == ADR_INSTR0)      prdata <= instr0;
        else if (apbReq.paddr == ADR_INSTR1) prdata <= nextAddress;
        else if (apbReq.paddr == ADR_SPTR)   prdata <= scriptPointer;
        else if (apbReq.paddr == ADR_DBASE)  prdata <= dataBase;
        else if (apbReq.paddr == ADR_CTRL)
          prdata <= {16'h0000, regFile[rAdr], 3'h0, loopback, sigProc,
                     reselected, selected, goReq};
        else if (apbReq.paddr == ADR_STAT)
          prdata <= {24'h000000, destId, state};
        else if (apbReq.paddr == ADR_ALU)
          prdata <= {16'h0000, latchBits, 5'h00, tableFetchReq,
                     carry, targetMode};
        else if (apbReq.paddr == ADR_NEXT)   prdata <= nextFetch;
        else if (apbReq.paddr == ADR_TFETCH) prdata <= tableFetch;
        else if (apbReq.paddr == ADR_REGW)   prdata <= {24'h000000, firstByte};
        else pslverr <= 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_waitSel;
    state == ST_WAIT && !sigProc && selected;
  endsequence

  property p_selAlt;
    @(posedge sys_clk) disable iff (!reset_n)
    s_waitSel |=> nextFetch == $past(altTarget);
  endproperty
  a_selAlt: assert property (p_selAlt)
    else $error("selected wait did not take alternate");

  property p_reselPtr;
    @(posedge sys_clk) disable iff (!reset_n)
    state == ST_WAIT && !sigProc && !selected && reselected
      |=> nextFetch == $past(scriptPointer);
  endproperty
  a_reselPtr: assert property (p_reselPtr)
    else $error("reselect did not take script pointer");

  property p_sigAbort;
    @(posedge sys_clk) disable iff (!reset_n)
    state == ST_WAIT && sigProc |=> state == ST_DONE
      && nextFetch == $past(altTarget);
  endproperty
  a_sigAbort: assert property (p_sigAbort)
    else $error("signal process did not abort wait");

  property p_illegal;
    @(posedge sys_clk) disable iff (!reset_n)
    state == ST_EXEC && iType == TYPE_IO && isIo && iOpc != OPC_SEL
      && instr0[BIT_SATN] |=> illegalIrq ##1 !illegalIrq;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal instruction not flagged");

  property p_setTm;
    @(posedge sys_clk) disable iff (!reset_n)
    state == ST_EXEC && iType == TYPE_IO && iOpc == OPC_SET
      && instr0[BIT_TM] && !instr0[BIT_SATN] |=> targetMode;
  endproperty
  a_setTm: assert property (p_setTm)
    else $error("set did not enter target mode");

  property p_clrCarry;
    @(posedge sys_clk) disable iff (!reset_n)
    state == ST_EXEC && iType == TYPE_IO && iOpc == OPC_CLR
      && instr0[BIT_CC] && !instr0[BIT_SATN] |=> !carry;
  endproperty
  a_clrCarry: assert property (p_clrCarry)
    else $error("clear did not clear carry");

  property p_drive;
    @(posedge sys_clk) disable iff (!reset_n)
    $past(targetMode) && !$past(loopback) |-> busDrive == '0;
  endproperty
  a_drive: assert property (p_drive)
    else $error("ack or atn driven as target");

  property p_dest;
    @(posedge sys_clk) disable iff (!reset_n)
    state == ST_EXEC && iType == TYPE_IO && isIo
      |=> destId == $past(instr0[DID_HI:DID_LO]);
  endproperty
  a_dest: assert property (p_dest)
    else $error("destination id wrong");

endmodule
`default_nettype wire

/* File: bench/ssrd_script_peer.sv */
// Behavioural script memory and bus peer model for the decoder bench
`timescale 1ns/1ns
`default_nettype none
module ssrd_script_peer;
  // ****************************************
  // Table layout and bus peer reactions
  // ****************************************
  // Entry bytes: config, id, offset/period, zero
  function automatic logic [31:0] entry(input logic [7:0] cfg,
                                        input logic [7:0] id,
                                        input logic [7:0] opr);
    return {cfg, id, opr, 8'h00};
  endfunction
  // Table offset stays within 8 Mbytes of the base
  function automatic logic [23:0] tbl_off(input logic [31:0] r);
    return r[23:0];
  endfunction
  // Peer reaction while the device waits: never none
  function automatic logic [2:0] events(input logic [31:0] r);
    return (r[2:0] == 3'h0) ? 3'h2 : r[2:0];
  endfunction
endmodule
`default_nettype wire

/* File: bench/tb_scsi_script_io_rw_decode.sv */
// Self-checking bench for the script I/O and read/write decoder
`timescale 1ns/1ns
`default_nettype none
module tb_scsi_script_io_rw_decode;
  import ssrd_pkg::*;
  // ****************************************
  // Clock, reset and design
  // ****************************************
  logic          sys_clk = 1'b0;
  logic          reset_n = 1'b0;
  ssrd_apb_req_t req = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  ssrd_latch_t   busDrive;
  logic          targetMode;
  logic          illegalIrq;
  logic          selAtn;
  int            miscompares = 0;
  int            cmp_count = 0;
  int            cycles = 0;
  int            irqSeen = 0;
  int            expIrq = 0;
  logic [31:0]   seed = 32'h1;
  logic [31:0]   rdq, rdErr, r, w, w1, sp, ex;
  logic          lp = 1'b0;
  logic          eAck = 1'b0, eAtn = 1'b0, eCy = 1'b0, eTm = 1'b0, v;
  logic [2:0]    ev, op, opc;
  logic [7:0]    rv, fb, imm, a, b, erg, efb;
  logic [8:0]    res;

  // Clock at 50 ns period
  always #25 sys_clk = ~sys_clk;

  ssrd_decoder u_ssrd_decoder (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .apbReq     (req),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .busDrive   (busDrive),
    .targetMode (targetMode),
    .illegalIrq (illegalIrq),
    .selAtn     (selAtn)
  );
  ssrd_script_peer u_ssrd_script_peer ();

  // ****************************************
  // Helpers
  // ****************************************
  // Pulse counter and hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (illegalIrq === 1'b1)
      irqSeen <= irqSeen + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] io(input logic [2:0] oc);
    logic [31:0] x;
    x = 32'h0;
    x[TYPE_HI:TYPE_LO] = TYPE_IO;
    x[OPC_HI:OPC_LO] = oc;
    return x;
  endfunction

  // Carry and result of one operator
  function automatic logic [8:0] alu(input logic [2:0] o,
                                     input logic [7:0] x,
                                     input logic [7:0] y,
                                     input logic c);
    case (o)
      3'h0: return {c, y};
      3'h1: return {x[7], x[6:0], c};
      3'h2: return {c, x | y};
      3'h3: return {c, x ^ y};
      3'h4: return {c, x & y};
      3'h5: return {x[0], c, x[7:1]};
      3'h6: return {1'b0, x} + {1'b0, y};
      default: return {1'b0, x} + {1'b0, y} + {8'h0, c};
    endcase
  endfunction

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= ad;
    req.pwdata  <= d;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rdq = prdata;
    rdErr = {31'h0, pslverr};
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Load both words, start, let the sequence settle
  task automatic exec(input logic [31:0] x0, input logic [31:0] x1,
                      input logic [2:0] e);
    apb(1'b1, ADR_INSTR0, x0);
    apb(1'b1, ADR_INSTR1, x1);
    apb(1'b1, ADR_CTRL, {27'h0, lp, e, 1'b1});
    apb(1'b0, ADR_STAT, 32'h0);
    apb(1'b0, ADR_STAT, 32'h0);
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    // Reset state, unmapped access
    apb(1'b1, 12'h0f0, 32'hffff_ffff);
    apb(1'b0, ADR_ALU, 32'h0);
    chk("alu reset", 32'h0, rdq);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped data", 32'h0, rdq);
    chk("unmapped err", 32'h1, rdErr);
    // Set and clear with random control, reserved and illegal bits
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      v = ~i[0];
      w = io(v ? OPC_SET : OPC_CLR) | (r & 32'h01ff_ffff);
      lp = r[31];
      if (w[BIT_SATN])
        expIrq++;
      else
      begin
        if (w[BIT_ACK]) eAck = v;
        if (w[BIT_ATN]) eAtn = v;
        if (w[BIT_CC]) eCy = v;
        if (w[BIT_TM]) eTm = v;
      end
      exec(w, rnd(), 3'h0);
      ex = {17'h0, eAck, 2'h0, eAtn, 9'h0, eCy, eTm};
      apb(1'b0, ADR_ALU, 32'h0);
      chk("alu", ex, rdq & 32'h0000_4803);
      chk("target", {31'h0, eTm}, {31'h0, targetMode});
      ex = {30'h0, {eAck, eAtn} & {2{~eTm | lp}}};
      chk("drive", ex, {30'h0, busDrive});
      chk("irq", expIrq, irqSeen);
      apb(1'b0, ADR_STAT, 32'h0);
      chk("dest", {28'h0, w[DID_HI:DID_LO]}, {28'h0, rdq[7:4]});
    end
    // Word of another type leaves latch, carry and mode alone
    exec(io(OPC_SET) ^ 32'hc000_0648, 32'h0, 3'h0);
    apb(1'b0, ADR_ALU, 32'h0);
    ex = {17'h0, eAck, 2'h0, eAtn, 9'h0, eCy, eTm};
    chk("type", ex, rdq & 32'h0000_4803);
    // Wait reselect under random mixes of bus events, never the empty mix
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      ev = u_ssrd_script_peer.events(r);
      w = io(OPC_WRES);
      w[BIT_REL] = r[3];
      w1 = rnd();
      sp = rnd();
      apb(1'b1, ADR_SPTR, sp);
      exec(w, w1, ev);
      ex = w[BIT_REL] ? sp + {{8{w1[23]}}, w1[23:0]} : w1;
      ex = (ev[2] | ev[0]) ? ex : sp;
      apb(1'b0, ADR_NEXT, 32'h0);
      chk("next", ex, rdq);
    end
    // Select with table fetch and attention bit
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      w = io(OPC_SEL);
      w[23:0] = u_ssrd_script_peer.tbl_off(rnd());
      w[BIT_TBL] = 1'b1;
      w[BIT_REL] = r[5];
      w[BIT_SATN] = r[6];
      sp = rnd();
      apb(1'b1, ADR_DBASE, sp);
      exec(w, rnd(), 3'h0);
      apb(1'b0, ADR_TFETCH, 32'h0);
      chk("table", sp + {{8{w[23]}}, w[23:0]}, rdq);
      apb(1'b0, ADR_ALU, 32'h0);
      chk("table req", 32'h4, rdq & 32'h4);
      chk("sel atn", {31'h0, w[BIT_SATN]}, {31'h0, selAtn});
    end
    // Read/write: every operator under each opcode
    for (int i = 0; i < 24; i++)
    begin
      r = rnd();
      op = i[2:0];
      opc = 3'h5 + 3'(i / 8);
      rv = r[15:8];
      fb = r[23:16];
      imm = r[31:24];
      v = r[25] & (op != OP_MOV) & (opc != OPC_MFROM);
      apb(1'b1, ADR_REGW, {17'h0, r[6:0], rv});
      exec(io(OPC_MTO) | {16'h0, fb, 8'h0}, 32'h0, 3'h0);
      exec(io(r[24] ? OPC_SET : OPC_CLR) | 32'h400, 32'h0, 3'h0);
      w = io(opc);
      w[OPR_HI:OPR_LO] = op;
      w[BIT_ACC] = v;
      w[RADR_HI:RADR_LO] = r[6:0];
      w[IMM_HI:IMM_LO] = imm;
      exec(w, 32'h0, 3'h0);
      a = (opc == OPC_MFROM) ? fb : rv;
      b = v ? fb : imm;
      res = alu(op, a, b, r[24]);
      erg = (opc == OPC_MTO) ? rv : res[7:0];
      efb = (opc == OPC_MTO) ? res[7:0] : fb;
      apb(1'b0, ADR_CTRL, 32'h0);
      chk("reg", {24'h0, erg}, {24'h0, rdq[15:8]});
      apb(1'b0, ADR_REGW, 32'h0);
      chk("first", {24'h0, efb}, {24'h0, rdq[7:0]});
      apb(1'b0, ADR_ALU, 32'h0);
      chk("carry", {31'h0, res[8]}, {31'h0, rdq[1]});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
